// *** rtl/tsp_pkg.sv ***
// tsp_pkg: constants for the tdm stream port (register map, modes, timing)
// assumes aclk at 250 MHz and a 32-bit axi4-lite register bus
package tsp_pkg;

  localparam int NUM_STREAMS = 4;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0C;
  localparam logic [7:0] ADDR_CLKDIV = 8'h10;

  // control field positions
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_MODE_LSB  = 1;   // 3 bits
  localparam int CTRL_VAR_LSB   = 4;   // 2 bits
  localparam int CTRL_CKPOL_BIT = 6;
  localparam int CTRL_EDGE_BIT  = 7;
  localparam int CTRL_FPPOL_BIT = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0100;
  localparam logic [15:0] CLKDIV_RESET = 16'h003C;

  // status field positions
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_BADCFG_BIT = 1;
  localparam int STAT_FRAME_BIT  = 2;

  // rate modes
  typedef enum logic [2:0] {
    TSP_M2    = 3'h0,
    TSP_M8    = 3'h1,
    TSP_MJ2   = 3'h2,
    TSP_ME3   = 3'h3,
    TSP_MT3   = 3'h4
  } tsp_mode_t;

  // device variants
  typedef enum logic [1:0] {
    TSP_V_SMALL = 2'h0,
    TSP_V_MID   = 2'h1,
    TSP_V_LARGE = 2'h2
  } tsp_var_t;

  // timeslots per frame for each mode
  localparam logic [9:0] SLOTS_2M  = 10'h020;  // 32
  localparam logic [9:0] SLOTS_8M  = 10'h080;  // 128
  localparam logic [9:0] SLOTS_J2  = 10'h062;  // 98
  localparam logic [9:0] SLOTS_E3  = 10'h219;  // 537
  localparam logic [9:0] SLOTS_T3  = 10'h2BB;  // 699
  localparam logic [9:0] DS0_MID   = 10'h040;  // 64 channel cap
  localparam logic [9:0] DS0_SMALL = 10'h020;  // 32 channel cap

  // frame period
  localparam int FRAME_US     = 125;
  localparam int CLK_MHZ      = 250;
  localparam int FRAME_CYCLES = FRAME_US * CLK_MHZ;

endpackage : tsp_pkg

// *** rtl/tsp_lane_if.sv ***
// tsp_lane_if: per-lane serial configuration and data bundle
// assumes the top drives cfg and the lane drives status
`timescale 1ns/1ps
interface tsp_lane_if;
  logic       rise;     // sample edge of the link clock
  logic       fall;     // launch edge of the link clock
  logic       frame;    // frame start strobe
  logic       enable;   // lane carries data
  logic       sin;      // synchronised serial input
  logic       sout;     // serial output
  logic [7:0] tx_byte;  // byte to launch
  logic [7:0] rx_byte;  // last byte captured
  logic       rx_done;  // one cycle when a byte completes

  modport top  (output rise, fall, frame, enable, sin, tx_byte,
                input sout, rx_byte, rx_done);
  modport lane (input rise, fall, frame, enable, sin, tx_byte,
                output sout, rx_byte, rx_done);
endinterface : tsp_lane_if

// *** rtl/tsp_lane.sv ***
// tsp_lane: one serial stream lane, shifts a byte in and out msb first
// assumes rise/fall are one-cycle edge strobes in the aclk domain
`timescale 1ns/1ps
module tsp_lane (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // lane bundle
  tsp_lane_if.lane  lif
);
  import tsp_pkg::*;

  logic [7:0] sh_in_r;
  logic [7:0] sh_out_r;
  logic [2:0] bit_r;
  logic [2:0] tbit_r;
  logic       sout_r;
  logic [7:0] rx_r;
  logic       done_r;

  wire last_bit = (bit_r == 3'h7);

  // receive shift; msb arrives first so shift left
  always_ff @(posedge aclk) begin
    if (!aresetn || lif.frame) begin
      sh_in_r <= 8'h00;
      bit_r   <= 3'h0;
      rx_r    <= rx_r & {8{aresetn}};
      done_r  <= 1'b0;
    end else if (lif.enable && lif.rise) begin
      sh_in_r <= {sh_in_r[6:0], lif.sin};
      bit_r   <= bit_r + 3'h1;
      done_r  <= last_bit;
      if (last_bit) rx_r <= {sh_in_r[6:0], lif.sin};
    end else begin
      done_r <= 1'b0;
    end
  end

  // transmit shift with its own bit count: launch trails sample by half
  // a bit, so reloading on the receive boundary would drop the lsb
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_out_r <= 8'h00;
      tbit_r   <= 3'h0;
      sout_r   <= 1'b0;
    end else if (lif.frame) begin
      sh_out_r <= lif.tx_byte;
      tbit_r   <= 3'h0;
    end else if (!lif.enable) begin
      sout_r   <= 1'b0;
    end else if (lif.fall) begin
      sout_r   <= sh_out_r[7];
      tbit_r   <= tbit_r + 3'h1;
      sh_out_r <= (tbit_r == 3'h7) ? lif.tx_byte : {sh_out_r[6:0], 1'b0};
    end
  end

  assign lif.sout    = sout_r;  // idle lanes cleared in the register
  assign lif.rx_byte = rx_r;
  assign lif.rx_done = done_r;
endmodule : tsp_lane

// *** rtl/tsp_top.sv ***
// tsp_top: tdm stream port, axi4-lite registers, clock edge detect, lanes
// assumes stream pins are asynchronous to aclk; aclk runs at 250 MHz
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module tsp_top #(
  parameter int FRAME_LEN = tsp_pkg::FRAME_CYCLES
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // tdm stream pins
  input  wire logic [3:0]  serial_stream_in,
  output logic [3:0]       serial_stream_out,
  input  wire logic [3:0]  stream_clock_in,
  output logic [3:0]       stream_clock_out,
  input  wire logic        frame_pulse_ref_in,
  output logic             frame_pulse_ref_out
);
  import tsp_pkg::*;

  localparam int N = NUM_STREAMS;

  // register state
  logic [31:0] ctrl_r;
  logic [31:0] act_r;      // ctrl copy taken at frame start
  logic [15:0] clkdiv_r;
  logic [15:0] divc_r;
  logic        clko_r;
  logic [31:0] tx_r;
  logic [31:0] rx_r;
  logic        frame_seen_r;
  logic        aw_r, w_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r, rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  bresp_r, rresp_r;

  // synchronisers: first stage feeds only the second
  logic [N-1:0] ck_s1_r, ck_s2_r, ck_d_r;
  logic [N-1:0] di_s1_r, di_s2_r;
  logic         fp_s1_r, fp_s2_r, fp_d_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ck_s1_r <= '0; ck_s2_r <= '0; ck_d_r <= '0;
      di_s1_r <= '0; di_s2_r <= '0;
      fp_s1_r <= 1'b0; fp_s2_r <= 1'b0; fp_d_r <= 1'b0;
    end else begin
      ck_s1_r <= stream_clock_in;
      ck_s2_r <= ck_s1_r;
      ck_d_r  <= ck_s2_r;
      di_s1_r <= serial_stream_in;
      di_s2_r <= di_s1_r;
      fp_s1_r <= frame_pulse_ref_in;
      fp_s2_r <= fp_s1_r;
      fp_d_r  <= fp_s2_r;
    end
  end

  // active configuration fields; frame pulse polarity read live from ctrl_r
  wire        cfg_en    = act_r[CTRL_EN_BIT];
  wire [2:0]  cfg_mode  = act_r[CTRL_MODE_LSB +: 3];
  wire [1:0]  cfg_var   = act_r[CTRL_VAR_LSB +: 2];
  wire        cfg_ckpol = act_r[CTRL_CKPOL_BIT];
  wire        cfg_edge  = act_r[CTRL_EDGE_BIT];
  wire        cfg_fppol = ctrl_r[CTRL_FPPOL_BIT];

  // polarity-corrected clock edges
  wire [N-1:0] ck_cur  = ck_s2_r ^ {N{cfg_ckpol}};
  wire [N-1:0] ck_prev = ck_d_r ^ {N{cfg_ckpol}};
  wire [N-1:0] ck_up   = ck_cur & ~ck_prev;
  wire [N-1:0] ck_dn   = ~ck_cur & ck_prev;
  // edge select: sample on one, launch on the other
  wire [N-1:0] smp_edge = cfg_edge ? ck_dn : ck_up;
  wire [N-1:0] lau_edge = cfg_edge ? ck_up : ck_dn;

  // frame pulse, polarity selectable, taken at its asserting edge
  wire fp_cur   = fp_s2_r ^ cfg_fppol;
  wire fp_prev  = fp_d_r ^ cfg_fppol;
  wire frame_in = fp_cur & ~fp_prev;

  // lanes allowed by variant and mode
  wire m2   = (cfg_mode == TSP_M2);
  wire m8   = (cfg_mode == TSP_M8);
  wire munst = (cfg_mode == TSP_MJ2) || (cfg_mode == TSP_ME3) ||
               (cfg_mode == TSP_MT3);
  wire vl   = (cfg_var == TSP_V_LARGE);
  wire vm   = (cfg_var == TSP_V_MID);
  wire vs   = (cfg_var == TSP_V_SMALL);
  wire cfg_ok = (m2 || m8 || (munst && vl)) && (vl || vm || vs);
  logic [N-1:0] lane_en;
  assign lane_en[0] = cfg_en && cfg_ok;
  assign lane_en[1] = cfg_en && cfg_ok && m2 && (vl || vm);
  assign lane_en[2] = cfg_en && cfg_ok && m2 && vl;
  assign lane_en[3] = cfg_en && cfg_ok && m2 && vl;

  // timeslots per frame
  wire [9:0] slots_mode =
      m2 ? SLOTS_2M :
      m8 ? SLOTS_8M :
      (cfg_mode == TSP_MJ2) ? SLOTS_J2 :
      (cfg_mode == TSP_ME3) ? SLOTS_E3 : SLOTS_T3;
  // channel caps for the smaller variants at 8 Mbps
  wire [9:0] slot_cap =
      (m8 && vm) ? DS0_MID : (m8 && vs) ? DS0_SMALL : slots_mode;

  // internal frame timer; an external pulse realigns it
  logic [$clog2(FRAME_LEN)-1:0] ftmr_r;
  wire ftmr_end = (ftmr_r == ($clog2(FRAME_LEN))'(FRAME_LEN - 1));
  wire frame_go = frame_in || ftmr_end;

  always_ff @(posedge aclk) begin
    if (!aresetn || frame_in) ftmr_r <= '0;
    else ftmr_r <= ftmr_end ? '0 : ftmr_r + 1'b1;
  end

  // configuration except frame pulse polarity copied into use only at a frame start
  always_ff @(posedge aclk) begin
    if (!aresetn) act_r <= CTRL_RESET;
    else if (frame_go) act_r <= ctrl_r;
  end

  // frame pulse out: one cycle at each frame start, none for a start on the cycle right after one
  logic fpo_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) fpo_r <= 1'b0;
    else fpo_r <= frame_go && !fpo_r;  // one cycle even if two starts abut
  end
  assign frame_pulse_ref_out = fpo_r ^ cfg_fppol;

  // timeslot counter shared by all lanes, advanced on lane 0, ts 0 follows frame
  logic [9:0] slot_r;
  logic       slot_act;
  assign slot_act = (slot_r < slot_cap);

  // lanes
  logic [N-1:0] rx_done;
  logic [7:0]   rx_b [N];
  logic [N-1:0] sout_w;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_lane
      tsp_lane_if lif ();
      assign lif.rise    = smp_edge[g];
      assign lif.fall    = lau_edge[g];
      assign lif.frame   = frame_go;
      assign lif.enable  = lane_en[g] && slot_act;
      assign lif.sin     = di_s2_r[g];
      assign lif.tx_byte = tx_r[8*g +: 8];
      assign sout_w[g]   = lif.sout;
      assign rx_b[g]     = lif.rx_byte;
      assign rx_done[g]  = lif.rx_done;
      tsp_lane u_lane (
        .aclk    (aclk),
        .aresetn (aresetn),
        .lif     (lif)
      );
    end
  endgenerate
  assign serial_stream_out = sout_w;

  always_ff @(posedge aclk) begin
    if (!aresetn || frame_go) slot_r <= 10'h000;
    else if (rx_done[0] && slot_act) slot_r <= slot_r + 10'h001;
  end

  // clock output divider; only enabled lanes toggle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      divc_r <= 16'h0000;
      clko_r <= 1'b0;
    end else if (divc_r >= clkdiv_r) begin
      divc_r <= 16'h0000;
      clko_r <= ~clko_r;
    end else begin
      divc_r <= divc_r + 16'h0001;
    end
  end
  assign stream_clock_out = {N{clko_r}} & lane_en;

  // captured bytes and frame flag (set wins over clear)
  wire rd_rx   = s_axi_arvalid && !rvalid_r && (s_axi_araddr == ADDR_STATUS);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_r <= 32'h0000_0000;
      frame_seen_r <= 1'b0;
    end else begin
      for (int i = 0; i < N; i++)
        if (rx_done[i]) rx_r[8*i +: 8] <= rx_b[i];
      if (frame_go) frame_seen_r <= 1'b1;
      else if (rd_rx) frame_seen_r <= 1'b0;
    end
  end

  // write decode; unmapped writes answer slverr
  wire wr_hit = (awaddr_r == ADDR_CTRL) || (awaddr_r == ADDR_TXDATA) ||
                (awaddr_r == ADDR_CLKDIV);

  // axi4-lite write: take address and data in either order
  wire do_wr = aw_r && w_r && !bvalid_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r <= 1'b0; w_r <= 1'b0; bvalid_r <= 1'b0;
      awaddr_r <= 8'h00; wdata_r <= 32'h0000_0000; wstrb_r <= 4'h0;
      bresp_r <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r <= 1'b1; awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_r <= 1'b1; wdata_r <= s_axi_wdata; wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_r <= 1'b0; w_r <= 1'b0; bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? 2'h0 : 2'h2;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_r && !bvalid_r;
  assign s_axi_wready  = !w_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  // byte strobe merge
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) if (s[b]) r[8*b +: 8] = d[8*b +: 8];
    return r;
  endfunction : merge
  // only the low half exists, upper strobes fall away
  wire [31:0] clkdiv_nxt = merge({16'h0000, clkdiv_r}, wdata_r, wstrb_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= CTRL_RESET;
      tx_r     <= 32'h0000_0000;
      clkdiv_r <= CLKDIV_RESET;
    end else if (do_wr) begin
      if (awaddr_r == ADDR_CTRL)   ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
      if (awaddr_r == ADDR_TXDATA) tx_r   <= merge(tx_r, wdata_r, wstrb_r);
      if (awaddr_r == ADDR_CLKDIV) clkdiv_r <= clkdiv_nxt[15:0];
    end
  end

  // read mux; unmapped reads answer slverr with zero data
  wire [31:0] stat_w = {29'h0, frame_seen_r, ~cfg_ok, cfg_en && cfg_ok};
  wire        rd_hit = (s_axi_araddr <= ADDR_CLKDIV) &&
                       (s_axi_araddr[1:0] == 2'h0);
  logic [31:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      ADDR_CTRL:   rd_mux = ctrl_r;
      ADDR_STATUS: rd_mux = stat_w;
      ADDR_TXDATA: rd_mux = tx_r;
      ADDR_RXDATA: rd_mux = rx_r;
      ADDR_CLKDIV: rd_mux = {16'h0000, clkdiv_r};
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0; rdata_r <= 32'h0000_0000; rresp_r <= 2'h0;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_hit ? 2'h0 : 2'h2;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
endmodule : tsp_top

// *** verification/tsp_top_sva.sv ***
// tsp_top_sva: port checks for the tdm stream port
// assumes software keeps the frame pulse active low
`timescale 1ns/1ps
module tsp_top_sva #(
  parameter int FRAME_LEN = 31250
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // stream pins
  input wire logic [3:0]  serial_stream_out,
  input wire logic [3:0]  stream_clock_out,
  input wire logic        frame_pulse_ref_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // both write channels taken on one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // one cycle low then idle high again
  sequence s_fp_pulse;
    !frame_pulse_ref_out ##1 frame_pulse_ref_out;
  endsequence

  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  AST_B_LATENCY: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read response late");
  AST_W_REFUSE: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  AST_R_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("bvalid held after bready");
  AST_B_CODE: assert property (s_axi_bvalid |->
    s_axi_bresp inside {2'h0, 2'h2}) else $error("bad bresp");
  AST_FP_ONE: assert property ($fell(frame_pulse_ref_out) |-> s_fp_pulse)
    else $error("frame pulse not one cycle");
  AST_RST_IDLE: assert property ($rose(aresetn) |->
    serial_stream_out == 4'h0 && stream_clock_out == 4'h0)
    else $error("stream outputs busy after reset");
endmodule : tsp_top_sva

bind tsp_top tsp_top_sva #(.FRAME_LEN(FRAME_LEN)) u_tsp_top_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .serial_stream_out(serial_stream_out),
  .stream_clock_out(stream_clock_out),
  .frame_pulse_ref_out(frame_pulse_ref_out));

// *** verification/tsp_framer.sv ***
// tsp_framer: backplane model, one frame of one byte per lane
// assumes the bench calls run_frame; link clock stands still between
`timescale 1ns/1ps
module tsp_framer (
  // link toward the port
  output logic [3:0]      clk_o,
  output logic [3:0]      data_o,
  output logic            frame_o,
  // port output observed
  input  wire logic [3:0] data_i
);
  // idle: clock parked, frame inactive, data pulled down
  initial begin
    clk_o = 4'h0;
    data_o = 4'h0;
    frame_o = 1'b1;
  end

  task automatic run_frame(input logic [31:0] snd, input logic inv,
                           output logic [31:0] cap);
    int b;
    int l;
    #1;                                // step off the aclk edge
    clk_o = {4{inv}};                  // polarity of this frame
    frame_o = 1'b0;                    // active low frame marker
    for (l = 0; l < 4; l++) data_o[l] = snd[8*l+7]; // msb first
    #40;
    frame_o = 1'b1;
    #20;
    // 80 ns link period; bit 0 of slot 0 follows the marker
    for (b = 0; b < 9; b++) begin
      clk_o = {4{~inv}};               // sample edge
      if (b > 0) for (l = 0; l < 4; l++) cap[8*l+8-b] = data_i[l];
      #40;
      clk_o = {4{inv}};                // launch edge
      for (l = 0; l < 4; l++) data_o[l] = (b < 7) ? snd[8*l+6-b] : 1'b0;
      #40;
    end
  endtask : run_frame
endmodule : tsp_framer

// *** verification/tb.sv ***
// tb: self-checking bench for tsp_top with the framer model
// assumes FRAME_LEN shortened to 400 aclk cycles
`timescale 1ns/1ps
module tb;
  import tsp_pkg::*;
  localparam int FL = 400;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, fpin, fpout;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v, txw, rxw, got, d;
  logic [3:0]  wstrb, sin, sout, cin, cout, seen, badout, pc;
  logic [1:0]  bresp, rresp, resp;
  int          mismatches, checks, seed, i, k, n, t0, per, m, v, p;

  tsp_top #(.FRAME_LEN(FL)) u_tsp_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_stream_in(sin),
    .serial_stream_out(sout), .stream_clock_in(cin),
    .stream_clock_out(cout), .frame_pulse_ref_in(fpin),
    .frame_pulse_ref_out(fpout));
  tsp_framer u_framer (.clk_o(cin), .data_o(sin), .frame_o(fpin),
    .data_i(sout));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // a wait that ran out ends the run at once
  task automatic hang(input string nm);
    chk(nm, 32'h1, 32'h0);
    summarize();
  endtask : hang

  task automatic tick(input int c);
    repeat (c) @(posedge aclk);
  endtask : tick

  // both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dt,
                    input logic [3:0] s);
    logic dn;
    dn = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dt;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int j = 0; j < 64 && !dn; j++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        dn = 1'b1;
        resp = bresp;
      end
    end
    bready <= 1'b0;
    if (!dn) hang("write_wait");
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic dn;
    dn = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int j = 0; j < 64 && !dn; j++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        dn = 1'b1;
        rd_v = rdata;
        resp = rresp;
      end
    end
    rready <= 1'b0;
    if (!dn) hang("read_wait");
  endtask : rd

  // lanes that may carry data for a mode and variant
  function automatic logic [3:0] lanes(input int md, input int vr);
    if (md == 0) return (vr == 2) ? 4'hF : (vr == 1) ? 4'h3 : 4'h1;
    if (md == 1) return 4'h1;
    return (vr == 2) ? 4'h1 : 4'h0;
  endfunction : lanes

  initial begin
    seed = 70;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, unmapped place, byte lanes
    rd(ADDR_CTRL);
    chk("ctrl_reset", CTRL_RESET, rd_v);
    rd(ADDR_CLKDIV);
    chk("clkdiv_reset", {16'h0000, CLKDIV_RESET}, rd_v);
    rd(8'h14);
    chk("rd_unmapped", 32'h2, {30'h0, resp});
    wr(8'h1C, 32'h0000_00FF, 4'hF);
    chk("wr_unmapped", 32'h2, {30'h0, resp});
    repeat (4) begin
      d = $random(seed);
      wr(ADDR_CLKDIV, d, 4'hF);
      wr(ADDR_CLKDIV, 32'hFFFF_FFFF, 4'h2);
      rd(ADDR_CLKDIV);
      chk("clkdiv_strb", {16'h0000, 8'hFF, d[7:0]}, rd_v);
      d = {23'h0, 1'b1, d[7:4], 3'($unsigned($random(seed)) % 5), 1'b0};
      wr(ADDR_CTRL, d, 4'hF);
      rd(ADDR_CTRL);
      chk("ctrl_rw", d, rd_v);
    end
    $display("test registers done");
    // every mode on every variant: lanes, clock period, bad config
    for (m = 0; m < 5; m++)
      for (v = 0; v < 3; v++) begin
        d = 32'h1 + ($unsigned($random(seed)) % 8);
        wr(ADDR_CLKDIV, d, 4'hF);
        wr(ADDR_CTRL, 32'h101 | (m << 1) | (v << 4), 4'hF);
        tick(FL + 20);
        seen = 4'h0;
        badout = 4'h0;
        per = 0;
        k = 0;
        pc = cout;
        repeat (80) begin
          @(posedge aclk);
          if (cout[0] !== pc[0]) begin
            per = k;
            k = 0;
          end
          k++;
          seen |= cout ^ pc;
          badout |= sout & ~lanes(m, v);
          pc = cout;
        end
        chk("lane_clocks", lanes(m, v), seen);
        chk("idle_data", 32'h0, badout);
        if (lanes(m, v) != 4'h0) chk("clk_period", d + 1, per);
        rd(ADDR_STATUS);
        chk("bad_config", lanes(m, v) == 4'h0, rd_v[STAT_BADCFG_BIT]);
      end
    $display("test lane table done");
    // free-running frame pulse spacing and sticky frame flag
    n = 0;
    for (i = 0; i < 3 * FL && n < 2; i++) begin
      @(posedge aclk);
      if (fpout === 1'b0) begin
        per = i - t0;
        t0 = i;
        n++;
      end
    end
    if (n < 2) hang("frame_wait");
    chk("frame_period", FL, per);
    rd(ADDR_STATUS);
    chk("frame_seen", 32'h1, rd_v[STAT_FRAME_BIT]);
    rd(ADDR_STATUS);
    chk("frame_clear", 32'h0, rd_v[STAT_FRAME_BIT]);
    $display("test frame pulse done");
    // one byte per lane both ways, both clock polarities
    for (p = 0; p < 2; p++) begin
      txw = p ? $random(seed) : 32'h8001_FF00;
      rxw = p ? $random(seed) : 32'h01FF_0080;
      wr(ADDR_TXDATA, txw, 4'hF);
      wr(ADDR_CTRL, 32'h121 | (p << 6), 4'hF);
      tick(FL + 20);
      u_framer.run_frame(rxw, p[0], got);
      chk("tx_bytes", txw, got);
      rd(ADDR_RXDATA);
      chk("rx_bytes", rxw, rd_v);
    end
    $display("test stream data done");
    summarize();
  end
endmodule : tb
